// ---- lila_cfg.svh ----
// Constants for the per-lane alignment-sequence and error counter register bank.
`ifndef LILA_CFG_SVH
`define LILA_CFG_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define LILA_NUM_LANES      4
`define LILA_ADDR_W         8
`define LILA_DATA_W         32
`define LILA_LANE_STRIDE_W  5

// ----------------------------------------------------------------------------
// Per-lane register offsets inside one lane window
// ----------------------------------------------------------------------------
`define LILA_OFS_PHASE_CFG  5'h00
`define LILA_OFS_CHECKSUM   5'h04
`define LILA_OFS_TEST_ERR   5'h08
`define LILA_OFS_LINK_ERR   5'h0C
`define LILA_OFS_ALIGN_SEQ  5'h10
`define LILA_OFS_MULTIFRAME 5'h14
`define LILA_OFS_BUF_FILL   5'h18

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define LILA_DIR_BIT        16
`define LILA_PHASE_ADJUST_REQUEST_BIT      8
`define LILA_ADJUST_STEP_COUNT_W       4
`define LILA_ADJUST_STEP_COUNT_RST     4'h0
`define LILA_CHECKSUM_W     8
`define LILA_FILL_W         10
`define LILA_COUNT_RST      32'h0000_0000

// ----------------------------------------------------------------------------
// Link test mode encodings
// ----------------------------------------------------------------------------
`define LILA_TMODE_K285     3'h1
`define LILA_TMODE_ILA      3'h2

`endif

// ---- lila_far_end.sv ----
// Far-end lane event source feeding the lane register bank.
`timescale 1ns/1ns

module lila_far_end (
	input  wire logic  ref_clk,
	output logic [3:0] charValid,
	output logic [3:0] charIsK285,
	output logic [3:0] dispErr,
	output logic [3:0] nitErr,
	output logic [3:0] alignSeqDone,
	output logic [3:0] multiframeDone
);
	initial begin
		{charValid, charIsK285, dispErr, nitErr, alignSeqDone, multiframeDone} = '0;
	end

	// Kinds: 0 other char, 1 K28.5, 2 disparity, 3 not in table, 4 both, 5 sequence,
	// 6 multiframe, 7 idle. Idle flips the character type so it never looks held.
	task drive(input int lane, input int kind);
		charValid[lane]      <= (kind < 2);
		charIsK285[lane]     <= (kind == 1) || (kind == 7 && !charIsK285[lane]);
		dispErr[lane]        <= (kind == 2) || (kind == 4);
		nitErr[lane]         <= (kind == 3) || (kind == 4);
		alignSeqDone[lane]   <= (kind == 5);
		multiframeDone[lane] <= (kind == 6);
	endtask : drive

	task pulse(input int lane, input int kind, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			drive(lane, kind);
		end
		@(posedge ref_clk);
		drive(lane, 7);
	endtask : pulse
endmodule : lila_far_end

// ---- lila_lane_counters.sv ----
// Per-lane test and link error counters.
`timescale 1ns/1ns
`include "lila_cfg.svh"

module lila_counters
	import lila_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire lila_tmode_t testMode,
	input  wire logic        errCountEnable,
	input  wire logic        charValid,
	input  wire logic        charIsK285,
	input  wire logic        dispErr,
	input  wire logic        nitErr,
	input  wire logic        alignSeqDone,
	input  wire logic        multiframeDone,
	output logic [31:0]      testErrCount,
	output logic [31:0]      linkErrCount,
	output logic [31:0]      alignSeqCount,
	output logic [31:0]      multiframeCount
);

	logic        prevIlaMode;
	logic        prevErrEnable;
	logic [31:0] next_testErrCount;
	logic [31:0] next_linkErrCount;
	logic [31:0] next_alignSeqCount;
	logic [31:0] next_multiframeCount;
	logic        ilaMode;
	logic [1:0]  errIncr;

	// ------------------------------------------------------------------------
	// Next-value logic
	// ------------------------------------------------------------------------
	always_comb begin
		ilaMode              = (testMode == `LILA_TMODE_ILA);
		errIncr              = {1'b0, dispErr} + {1'b0, nitErr};
		next_testErrCount    = testErrCount;
		next_linkErrCount    = linkErrCount;
		next_alignSeqCount   = alignSeqCount;
		next_multiframeCount = multiframeCount;
		if (testMode == `LILA_TMODE_K285 && charValid && !charIsK285) begin
			next_testErrCount = testErrCount + 32'h0000_0001;
		end
		if (errCountEnable && !prevErrEnable) begin
			next_linkErrCount = `LILA_COUNT_RST;
		end else if (errCountEnable) begin
			next_linkErrCount = linkErrCount + {30'h0000_0000, errIncr};
		end
		if (ilaMode && !prevIlaMode) begin
			next_alignSeqCount   = `LILA_COUNT_RST;
			next_multiframeCount = `LILA_COUNT_RST;
		end else if (ilaMode) begin
			if (alignSeqDone) begin
				next_alignSeqCount = alignSeqCount + 32'h0000_0001;
			end
			if (multiframeDone) begin
				next_multiframeCount = multiframeCount + 32'h0000_0001;
			end
		end
	end

	// ------------------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			prevIlaMode     <= 1'b0;
			prevErrEnable   <= 1'b0;
			testErrCount    <= `LILA_COUNT_RST;
			linkErrCount    <= `LILA_COUNT_RST;
			alignSeqCount   <= `LILA_COUNT_RST;
			multiframeCount <= `LILA_COUNT_RST;
		end else begin
			prevIlaMode     <= ilaMode;
			prevErrEnable   <= errCountEnable;
			testErrCount    <= next_testErrCount;
			linkErrCount    <= next_linkErrCount;
			alignSeqCount   <= next_alignSeqCount;
			multiframeCount <= next_multiframeCount;
		end
	end

endmodule : lila_counters

// ---- lila_lane_regs.sv ----
// Phase-adjust configuration (per lane on receive, one shared set on transmit), per-lane checksum and counter register bank.
`timescale 1ns/1ns
`include "lila_cfg.svh"

module lila_lane_regs
	import lila_pkg::*;
#(
	parameter bit IS_TX = 1'b0
)
(
	input  wire logic                                        ref_clk,
	input  wire logic                                        resetn,
	input  wire logic [`LILA_ADDR_W-1:0]                     regAddr,
	input  wire logic                                        regWrEn,
	input  wire logic [`LILA_DATA_W-1:0]                     regWrData,
	input  wire logic                                        regRdEn,
	output logic [`LILA_DATA_W-1:0]                          regRdData,
	output logic                                             regRdValid,
	input  wire lila_tmode_t                                 testMode,
	input  wire logic                                        errCountEnable,
	input  wire logic [`LILA_NUM_LANES-1:0]                  charValid,
	input  wire logic [`LILA_NUM_LANES-1:0]                  charIsK285,
	input  wire logic [`LILA_NUM_LANES-1:0]                  dispErr,
	input  wire logic [`LILA_NUM_LANES-1:0]                  nitErr,
	input  wire logic [`LILA_NUM_LANES-1:0]                  alignSeqDone,
	input  wire logic [`LILA_NUM_LANES-1:0]                  multiframeDone,
	input  wire logic [`LILA_NUM_LANES-1:0]                  captureValid,
	input  wire logic [`LILA_NUM_LANES-1:0]                  capAdjustDirection,
	input  wire logic [`LILA_NUM_LANES-1:0]                  capPhaseAdjustRequest,
	input  wire logic [`LILA_NUM_LANES*`LILA_ADJUST_STEP_COUNT_W-1:0]   capAdjustStepCount,
	input  wire logic [`LILA_NUM_LANES*`LILA_CHECKSUM_W-1:0] capConfigChecksum,
	input  wire logic [`LILA_NUM_LANES*`LILA_CHECKSUM_W-1:0] txPartialSum,
	input  wire logic [`LILA_NUM_LANES*`LILA_FILL_W-1:0]     bufFillLevel,
	output logic                                             txAdjustDirection,
	output logic                                             txPhaseAdjustRequest,
	output logic [`LILA_ADJUST_STEP_COUNT_W-1:0]                        txAdjustStepCount,
	output logic [`LILA_NUM_LANES*`LILA_CHECKSUM_W-1:0]      txConfigChecksum
);

	localparam int NL = `LILA_NUM_LANES;
	localparam int CW = `LILA_CHECKSUM_W;
	localparam int AW = `LILA_ADJUST_STEP_COUNT_W;
	localparam int FW = `LILA_FILL_W;

	// ------------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------------
	function automatic lila_sel_e decodeSel(input logic [`LILA_ADDR_W-1:0] addr);
		lila_sel_e sel;
		sel = LILA_SEL_NONE;
		if (int'(addr[`LILA_ADDR_W-1:`LILA_LANE_STRIDE_W]) < NL) begin
			case (addr[`LILA_LANE_STRIDE_W-1:0])
				`LILA_OFS_PHASE_CFG:  sel = LILA_SEL_PHASE_CFG;
				`LILA_OFS_CHECKSUM:   sel = LILA_SEL_CHECKSUM;
				`LILA_OFS_TEST_ERR:   sel = LILA_SEL_TEST_ERR;
				`LILA_OFS_LINK_ERR:   sel = LILA_SEL_LINK_ERR;
				`LILA_OFS_ALIGN_SEQ:  sel = LILA_SEL_ALIGN_SEQ;
				`LILA_OFS_MULTIFRAME: sel = LILA_SEL_MULTIFRAME;
				`LILA_OFS_BUF_FILL:   sel = LILA_SEL_BUF_FILL;
				default:              sel = LILA_SEL_NONE;
			endcase
		end
		return sel;
	endfunction : decodeSel

	function automatic logic [1:0] laneOf(input logic [`LILA_ADDR_W-1:0] addr);
		return addr[`LILA_LANE_STRIDE_W+1:`LILA_LANE_STRIDE_W];
	endfunction : laneOf

	// ------------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------------
	logic [NL-1:0]    rxDir;
	logic [NL-1:0]    rxPhadj;
	logic [AW-1:0]    rxAdjCnt [NL];
	logic [CW-1:0]    checksum [NL];
	logic [FW-1:0]    fillLevel [NL];
	logic [31:0]      testErrCount [NL];
	logic [31:0]      linkErrCount [NL];
	logic [31:0]      alignSeqCount [NL];
	logic [31:0]      multiframeCount [NL];
	logic [NL-1:0]    next_rxDir;
	logic [NL-1:0]    next_rxPhadj;
	logic [AW-1:0]    next_rxAdjCnt [NL];
	logic [CW-1:0]    next_checksum [NL];
	logic [FW-1:0]    next_fillLevel [NL];
	logic             next_txDir;
	logic             next_txPhadj;
	logic [AW-1:0]    next_txAdjCnt;
	logic [NL*CW-1:0] next_txConfigChecksum;
	logic [31:0]      next_regRdData;
	logic             next_regRdValid;
	lila_sel_e        wrSel;
	lila_sel_e        rdSel;
	logic [1:0]       rdLane;

	// ------------------------------------------------------------------------
	// Per-lane counters
	// ------------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NL; g++) begin : gLane
			lila_counters uCnt (
				.ref_clk         (ref_clk),
				.resetn          (resetn),
				.testMode        (testMode),
				.errCountEnable  (errCountEnable),
				.charValid       (charValid[g]),
				.charIsK285      (charIsK285[g]),
				.dispErr         (dispErr[g]),
				.nitErr          (nitErr[g]),
				.alignSeqDone    (alignSeqDone[g]),
				.multiframeDone  (multiframeDone[g]),
				.testErrCount    (testErrCount[g]),
				.linkErrCount    (linkErrCount[g]),
				.alignSeqCount   (alignSeqCount[g]),
				.multiframeCount (multiframeCount[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Configuration, capture and checksum next values
	// ------------------------------------------------------------------------
	always_comb begin
		wrSel         = decodeSel(regAddr);
		next_txDir    = txAdjustDirection;
		next_txPhadj  = txPhaseAdjustRequest;
		next_txAdjCnt = txAdjustStepCount;
		next_rxDir    = rxDir;
		next_rxPhadj  = rxPhadj;
		if (IS_TX && regWrEn && wrSel == LILA_SEL_PHASE_CFG) begin
			next_txDir    = regWrData[`LILA_DIR_BIT];
			next_txPhadj  = regWrData[`LILA_PHASE_ADJUST_REQUEST_BIT];
			next_txAdjCnt = regWrData[AW-1:0];
		end
		next_txConfigChecksum = '0;
		for (int i = 0; i < NL; i++) begin
			next_rxAdjCnt[i]  = rxAdjCnt[i];
			next_checksum[i]  = checksum[i];
			next_fillLevel[i] = bufFillLevel[i*FW +: FW];
			if (IS_TX) begin
				// Checksum follows the programmed fields; software writes never land.
				next_checksum[i] = txPartialSum[i*CW +: CW] + CW'(next_txDir)
					+ CW'(next_txPhadj) + CW'(next_txAdjCnt);
			end else if (captureValid[i]) begin
				next_rxDir[i]    = capAdjustDirection[i];
				next_rxPhadj[i]  = capPhaseAdjustRequest[i];
				next_rxAdjCnt[i] = capAdjustStepCount[i*AW +: AW];
				next_checksum[i] = capConfigChecksum[i*CW +: CW];
			end
			next_txConfigChecksum[i*CW +: CW] = IS_TX ? next_checksum[i] : '0;
		end
	end

	// ------------------------------------------------------------------------
	// Read path next values
	// ------------------------------------------------------------------------
	always_comb begin
		rdSel           = decodeSel(regAddr);
		rdLane          = laneOf(regAddr);
		next_regRdValid = regRdEn;
		next_regRdData  = regRdData;
		if (regRdEn) begin
			next_regRdData = '0;
			case (rdSel)
				LILA_SEL_PHASE_CFG: begin
					if (IS_TX) begin
						next_regRdData[`LILA_DIR_BIT]   = txAdjustDirection;
						next_regRdData[`LILA_PHASE_ADJUST_REQUEST_BIT] = txPhaseAdjustRequest;
						next_regRdData[AW-1:0]          = txAdjustStepCount;
					end else begin
						next_regRdData[`LILA_DIR_BIT]   = rxDir[rdLane];
						next_regRdData[`LILA_PHASE_ADJUST_REQUEST_BIT] = rxPhadj[rdLane];
						next_regRdData[AW-1:0]          = rxAdjCnt[rdLane];
					end
				end
				LILA_SEL_CHECKSUM:   next_regRdData[CW-1:0] = checksum[rdLane];
				LILA_SEL_TEST_ERR:   next_regRdData = testErrCount[rdLane];
				LILA_SEL_LINK_ERR:   next_regRdData = linkErrCount[rdLane];
				LILA_SEL_ALIGN_SEQ:  next_regRdData = alignSeqCount[rdLane];
				LILA_SEL_MULTIFRAME: next_regRdData = multiframeCount[rdLane];
				LILA_SEL_BUF_FILL:   next_regRdData[FW-1:0] = fillLevel[rdLane];
				default:             next_regRdData = '0;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			txAdjustDirection    <= 1'b0;
			txPhaseAdjustRequest <= 1'b0;
			txAdjustStepCount    <= `LILA_ADJUST_STEP_COUNT_RST;
			txConfigChecksum     <= '0;
			rxDir                <= '0;
			rxPhadj              <= '0;
			regRdData            <= '0;
			regRdValid           <= 1'b0;
			for (int i = 0; i < NL; i++) begin
				rxAdjCnt[i]  <= `LILA_ADJUST_STEP_COUNT_RST;
				checksum[i]  <= '0;
				fillLevel[i] <= '0;
			end
		end else begin
			txAdjustDirection    <= next_txDir;
			txPhaseAdjustRequest <= next_txPhadj;
			txAdjustStepCount    <= next_txAdjCnt;
			txConfigChecksum     <= next_txConfigChecksum;
			rxDir                <= next_rxDir;
			rxPhadj              <= next_rxPhadj;
			regRdData            <= next_regRdData;
			regRdValid           <= next_regRdValid;
			for (int i = 0; i < NL; i++) begin
				rxAdjCnt[i]  <= next_rxAdjCnt[i];
				checksum[i]  <= next_checksum[i];
				fillLevel[i] <= next_fillLevel[i];
			end
		end
	end

endmodule : lila_lane_regs

// ---- lila_lane_regs_props.sv ----
// Port checks for the lane register bank.
`timescale 1ns/1ns
`include "lila_cfg.svh"

module lila_lane_regs_props #(
	parameter bit IS_TX = 1'b0
)
(
	input wire logic        ref_clk,
	input wire logic        resetn,
	input wire logic [7:0]  regAddr,
	input wire logic        regWrEn,
	input wire logic [31:0] regWrData,
	input wire logic        regRdEn,
	input wire logic [31:0] regRdData,
	input wire logic        regRdValid,
	input wire logic [31:0] txPartialSum,
	input wire logic        txAdjustDirection,
	input wire logic        txPhaseAdjustRequest,
	input wire logic [3:0]  txAdjustStepCount,
	input wire logic [31:0] txConfigChecksum
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	read_answer_a: assert property (regRdValid == $past(regRdEn))
		else $error("read valid not one cycle after the read strobe");
	phase_reserved_a: assert property (regRdEn && regAddr[4:0] == 5'h00
		|=> (regRdData & 32'hFFFE_FEF0) == 32'h0) else $error("phase config reserved bits set");
	sum_reserved_a: assert property (regRdEn && regAddr[4:0] == 5'h04
		|=> regRdData[31:8] == 24'h0) else $error("checksum reserved bits set");
	fill_reserved_a: assert property (regRdEn && regAddr[4:0] == 5'h18
		|=> regRdData[31:10] == 22'h0) else $error("fill level reserved bits set");
	unmapped_zero_a: assert property (regRdEn && regAddr[4:0] == 5'h1C
		|=> regRdData == 32'h0) else $error("unmapped read not zero");
	tx_program_a: assert property (IS_TX && regWrEn && !regAddr[7] && regAddr[4:0] == 5'h00
		|=> {txAdjustDirection, txPhaseAdjustRequest, txAdjustStepCount}
		== {$past(regWrData[16]), $past(regWrData[8]), $past(regWrData[3:0])})
		else $error("programmed phase fields not sent");
	rx_quiet_a: assert property (!IS_TX |-> !txAdjustDirection && !txPhaseAdjustRequest
		&& txAdjustStepCount == 4'h0 && txConfigChecksum == 32'h0)
		else $error("receiver drives transmit fields");
	for (genvar i = 0; i < 4; i++) begin : g_sum
		// The checksum register loads with the fields it covers, so it tracks their present value.
		checksum_auto_a: assert property (IS_TX && $past(resetn) |-> txConfigChecksum[8*i +: 8]
			== 8'($past(txPartialSum[8*i +: 8]) + txAdjustDirection + txPhaseAdjustRequest
			+ txAdjustStepCount)) else $error("lane checksum not computed");
	end
endmodule : lila_lane_regs_props

// ---- lila_pkg.sv ----
// Types shared by the lane register bank and its counter module.
package lila_pkg;

	typedef logic [2:0] lila_tmode_t;

	typedef enum {
		LILA_SEL_PHASE_CFG,
		LILA_SEL_CHECKSUM,
		LILA_SEL_TEST_ERR,
		LILA_SEL_LINK_ERR,
		LILA_SEL_ALIGN_SEQ,
		LILA_SEL_MULTIFRAME,
		LILA_SEL_BUF_FILL,
		LILA_SEL_NONE
	} lila_sel_e;

endpackage : lila_pkg

// ---- test_lila_lane_regs.sv ----
// Self-checking bench for the lane register bank, receiver and transmitter.
`timescale 1ns/1ns

module test_lila_lane_regs;
	logic                  ref_clk;
	logic                  resetn;
	logic [7:0]            regAddr;
	logic                  regWrEn;
	logic                  regRdEn;
	logic [31:0]           regWrData;
	logic [31:0]           rxRdData;
	logic [31:0]           txRdData;
	logic                  rxRdValid;
	logic                  txRdValid;
	lila_pkg::lila_tmode_t testMode;
	logic                  errCountEnable;
	logic [3:0]            charValid, charIsK285, dispErr, nitErr, alignSeqDone, multiframeDone;
	logic [3:0]            captureValid, capAdjustDirection, capPhaseAdjustRequest;
	logic [15:0]           capAdjustStepCount;
	logic [31:0]           capConfigChecksum, txPartialSum, txConfigChecksum;
	logic [39:0]           bufFillLevel;
	logic                  txAdjustDirection, txPhaseAdjustRequest;
	logic [3:0]            txAdjustStepCount;
	int                    errors = 0;
	int                    total_checks = 0;

	lila_lane_regs #(.IS_TX(1'b0)) u_lila_lane_regs (.ref_clk, .resetn, .regAddr, .regWrEn,
		.regWrData, .regRdEn, .regRdData(rxRdData), .regRdValid(rxRdValid), .testMode,
		.errCountEnable, .charValid, .charIsK285, .dispErr, .nitErr, .alignSeqDone,
		.multiframeDone, .captureValid, .capAdjustDirection, .capPhaseAdjustRequest,
		.capAdjustStepCount, .capConfigChecksum, .txPartialSum, .bufFillLevel,
		.txAdjustDirection(), .txPhaseAdjustRequest(), .txAdjustStepCount(), .txConfigChecksum());
	lila_lane_regs #(.IS_TX(1'b1)) u_lila_lane_regs_tx (.ref_clk, .resetn, .regAddr, .regWrEn,
		.regWrData, .regRdEn, .regRdData(txRdData), .regRdValid(txRdValid), .testMode,
		.errCountEnable, .charValid, .charIsK285, .dispErr, .nitErr, .alignSeqDone,
		.multiframeDone, .captureValid, .capAdjustDirection, .capPhaseAdjustRequest,
		.capAdjustStepCount, .capConfigChecksum, .txPartialSum, .bufFillLevel,
		.txAdjustDirection, .txPhaseAdjustRequest, .txAdjustStepCount, .txConfigChecksum);
	lila_far_end u_lila_far_end (.ref_clk, .charValid, .charIsK285, .dispErr, .nitErr,
		.alignSeqDone, .multiframeDone);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic complete_run;
		$display("checks %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
	endtask : wr

	// Reads one word; tx selects which instance's answer is compared.
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input bit tx);
		@(posedge ref_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		#1;
		chk("read valid", 32'(tx ? txRdValid : rxRdValid), 32'h1);
		chk("read data", tx ? txRdData : rxRdData, exp);
	endtask : rchk

	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		complete_run();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		{regAddr, regWrEn, regWrData, regRdEn, testMode, errCountEnable} = '0;
		{captureValid, capAdjustDirection, capPhaseAdjustRequest, capAdjustStepCount} = '0;
		capConfigChecksum = 32'h0;
		txPartialSum = 32'hF3F2_F1F0;
		bufFillLevel = {10'h3FF, 10'h200, 10'h155, 10'h001};
		resetn = 1'b0;
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		for (int l = 0; l < 4; l++) begin
			for (int o = 0; o < 6; o++) begin
				rchk(8'(l * 32 + o * 4), 32'h0, 1'b0);
			end
			rchk(8'(l * 32 + 28), 32'h0, 1'b0);
			rchk(8'(l * 32), 32'h0, 1'b1);
			rchk(8'(l * 32 + 24), 32'(bufFillLevel[l * 10 +: 10]), 1'b0);
		end
		$display("test reset values done");
		@(posedge ref_clk);
		capAdjustDirection <= 4'h4;
		capPhaseAdjustRequest <= 4'h2;
		capAdjustStepCount <= 16'h09F0;
		capConfigChecksum <= 32'h00A5_3C00;
		captureValid <= 4'h6;
		@(posedge ref_clk);
		captureValid <= 4'h0;
		{capAdjustDirection, capPhaseAdjustRequest, capAdjustStepCount} <= '1;
		rchk(8'h40, 32'h0001_0009, 1'b0);
		rchk(8'h44, 32'h0000_00A5, 1'b0);
		rchk(8'h20, 32'h0000_010F, 1'b0);
		rchk(8'h24, 32'h0000_003C, 1'b0);
		rchk(8'h00, 32'h0, 1'b0);
		wr(8'h20, 32'hFFFF_FFFF);
		rchk(8'h20, 32'h0000_010F, 1'b0);
		rchk(8'h60, 32'h0001_010F, 1'b1);
		wr(8'h04, 32'hFFFF_FFFF);
		#1;
		for (int l = 0; l < 4; l++) begin
			chk("lane checksum", 32'(txConfigChecksum[l * 8 +: 8]), 32'(8'(240 + l + 17)));
		end
		rchk(8'h64, 32'h0000_0004, 1'b1);
		$display("test capture and program done");
		u_lila_far_end.pulse(0, 0, 2);
		rchk(8'h08, 32'h0, 1'b0);
		@(posedge ref_clk);
		testMode <= 3'h1;
		u_lila_far_end.pulse(0, 1, 3);
		u_lila_far_end.pulse(0, 0, 2);
		u_lila_far_end.pulse(3, 1, 4);
		rchk(8'h08, 32'h2, 1'b0);
		rchk(8'h68, 32'h0, 1'b0);
		$display("test character errors done");
		@(posedge ref_clk);
		errCountEnable <= 1'b1;
		u_lila_far_end.pulse(1, 4, 1);
		u_lila_far_end.pulse(1, 2, 1);
		u_lila_far_end.pulse(1, 3, 2);
		rchk(8'h2C, 32'h5, 1'b0);
		@(posedge ref_clk);
		errCountEnable <= 1'b0;
		u_lila_far_end.pulse(1, 4, 3);
		rchk(8'h2C, 32'h5, 1'b0);
		@(posedge ref_clk);
		errCountEnable <= 1'b1;
		rchk(8'h2C, 32'h0, 1'b0);
		$display("test link errors done");
		@(posedge ref_clk);
		testMode <= 3'h2;
		u_lila_far_end.pulse(3, 5, 3);
		u_lila_far_end.pulse(3, 6, 5);
		@(posedge ref_clk);
		testMode <= 3'h0;
		u_lila_far_end.pulse(3, 5, 2);
		u_lila_far_end.pulse(3, 6, 2);
		rchk(8'h70, 32'h3, 1'b0);
		rchk(8'h74, 32'h5, 1'b0);
		@(posedge ref_clk);
		testMode <= 3'h2;
		rchk(8'h70, 32'h0, 1'b0);
		rchk(8'h74, 32'h0, 1'b0);
		$display("test alignment counts done");
		complete_run();
	end
endmodule : test_lila_lane_regs

bind lila_lane_regs lila_lane_regs_props #(.IS_TX(IS_TX)) u_lila_lane_regs_props (.ref_clk,
	.resetn, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData, .regRdValid, .txPartialSum,
	.txAdjustDirection, .txPhaseAdjustRequest, .txAdjustStepCount, .txConfigChecksum);
